// File: inc/pmicim_pkg.sv
// constants, register map and carrier types for the interrupt mask and status block
// assumes a serial-bus front end that turns transfers into one-cycle register requests
package pmicim_pkg;

  // register subaddresses
  localparam logic [7:0] PMICIM_ADDR_FLAG_SYS = 8'h01;
  localparam logic [7:0] PMICIM_ADDR_FLAG_SW = 8'h02;
  localparam logic [7:0] PMICIM_ADDR_MASK_SYS = 8'h03;
  localparam logic [7:0] PMICIM_ADDR_MASK_SW = 8'h04;
  localparam logic [7:0] PMICIM_ADDR_STATUS = 8'h05;
  localparam logic [7:0] PMICIM_ADDR_CONTROL = 8'h06;

  // reset and fill values
  localparam logic [7:0] PMICIM_DATA_ZERO = 8'h00;
  localparam logic [5:0] PMICIM_MASK_RST = 6'h00;
  localparam logic [7:0] PMICIM_STATUS_RST = 8'h00;
  localparam logic [1:0] PMICIM_RSVD = 2'h0;
  localparam logic [1:0] PMICIM_PINS_IDLE = 2'h3;

  // source layout: low group mirrors system mask, high group the switch mask
  localparam int PMICIM_GRP_W = 6;
  localparam int PMICIM_SRC_N = 12;
  localparam int PMICIM_SRC_PROG_DONE = 0;
  localparam int PMICIM_SRC_COIN_DONE = 1;
  localparam int PMICIM_SRC_THERMAL = 2;
  localparam int PMICIM_SRC_BUTTON = 3;
  localparam int PMICIM_SRC_ADAPTER = 4;
  localparam int PMICIM_SRC_PROG_V = 5;

  // status field positions
  localparam int PMICIM_ST_SEAL = 7;
  localparam int PMICIM_ST_NVM = 6;
  localparam int PMICIM_ST_ADAPTER = 5;
  localparam int PMICIM_ST_BUTTON = 4;
  localparam int PMICIM_ST_STATE_MSB = 3;
  localparam int PMICIM_ST_STATE_LSB = 2;
  localparam int PMICIM_ST_COIN_MSB = 1;
  localparam int PMICIM_ST_COIN_LSB = 0;

  // control field and pin history bit positions
  localparam int PMICIM_CTL_ACQ = 0;
  localparam int PMICIM_PIN_ADAPTER = 0;
  localparam int PMICIM_PIN_BUTTON = 1;

  typedef enum logic [1:0] {
    PMICIM_PWR_TRANSITION = 2'h0,
    PMICIM_PWR_WAIT_ENABLE = 2'h1,
    PMICIM_PWR_ACTIVE = 2'h2,
    PMICIM_PWR_SUSPEND = 2'h3
  } pmicim_pwr_t;

  typedef enum logic [1:0] {
    PMICIM_COIN_BELOW_LOW = 2'h0,
    PMICIM_COIN_LOW = 2'h1,
    PMICIM_COIN_GOOD = 2'h2,
    PMICIM_COIN_IDEAL = 2'h3
  } pmicim_coin_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmicim_req_t;

  typedef struct packed {
    logic prog_voltage_low;
    logic thermal_warn;
    logic coin_acq_done;
    logic prog_done;
    logic [2:0] switch_fault;
    logic [2:0] switch_limit;
  } pmicim_evt_t;

  typedef struct packed {
    logic freshness_seal_broken;
    logic nvm_defaults_modified;
    logic adapter_detect_pin;
    logic push_button_pin;
    pmicim_pwr_t power_state;
    pmicim_coin_t coin_cell_level;
  } pmicim_mon_t;

endpackage

// File: rtl/pmicim_src_flag.sv
// one sticky interrupt flag per source
// assumes event and clear are synchronous one-cycle levels on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pmicim_src_flag (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag_out
);

  logic flag_reg;
  logic flag_next;

  // a set arriving with the clear is kept
  always_comb
  begin
    flag_next = flag_reg;
    if (clear_in)
    begin
      flag_next = 1'b0;
    end
    if (event_in)
    begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule
`default_nettype wire

// File: rtl/pmic_irq_mask_status.sv
// interrupt masking, sticky source flags and status reporting of the power manager
// assumes a bus front end issuing one-cycle register requests and synchronous pins
//
// Overview of operation
// - unmasked source event drives the low-active interrupt output low; masked leaves it
// - masked sources still detected and flagged; mask only blocks the interrupt output
// - system mask register bits 5..0 per source, bits 7-6 read zero
// - switch mask register: fault masks bits 5..3, current-limit masks bits 2..0
// - switch mask register resets to all zeros, every switch source unmasked
// - status bit 7 reads 1 once freshness seal is broken
// - status bit 6 reads 1 once non-volatile defaults differ from factory
// - status bit 5 is 1 while the adapter-detect pin is low
// - status bit 4 is 1 while the push-button pin is low
// - status bits 3-2 report the power state machine state
// - status bits 1-0 report the coin-cell charge level
// - status bits 7-6 reset to zero; lower bits follow live conditions
// - writing 1 to the acquisition start bit starts a measurement, bit self-clears
// - adapter and button flags set on every pin level change, both directions
`timescale 1ns/1ps
`default_nettype none
module pmic_irq_mask_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pmicim_pkg::pmicim_req_t req,
  input wire pmicim_pkg::pmicim_evt_t evt,
  input wire pmicim_pkg::pmicim_mon_t mon,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic coin_acq_start,
  output logic irq_out_low
);

  function automatic logic wr_hit(input pmicim_pkg::pmicim_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_hit(input pmicim_pkg::pmicim_req_t r, input logic [7:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction

  logic [pmicim_pkg::PMICIM_GRP_W-1:0] mask_sys_reg;
  logic [pmicim_pkg::PMICIM_GRP_W-1:0] mask_sys_next;
  logic [pmicim_pkg::PMICIM_GRP_W-1:0] mask_sw_reg;
  logic [pmicim_pkg::PMICIM_GRP_W-1:0] mask_sw_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [1:0] pins_prev_reg;
  logic [1:0] pins_prev_next;
  logic primed_reg;
  logic primed_next;
  logic acq_reg;
  logic acq_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  logic [1:0] pins_now;
  logic [1:0] pin_change;
  logic [pmicim_pkg::PMICIM_SRC_N-1:0] src_event;
  logic [pmicim_pkg::PMICIM_SRC_N-1:0] src_clear;
  logic [pmicim_pkg::PMICIM_SRC_N-1:0] flags;
  logic [pmicim_pkg::PMICIM_SRC_N-1:0] all_mask;
  logic rd_flag_sys;
  logic rd_flag_sw;

  assign pins_now = {mon.push_button_pin, mon.adapter_detect_pin};
  // first sample after reset only primes the history, so no false change
  assign pin_change = primed_reg ? (pins_now ^ pins_prev_reg) : 2'h0;

  assign src_event = {evt.switch_fault,
                      evt.switch_limit,
                      evt.prog_voltage_low,
                      pin_change[pmicim_pkg::PMICIM_PIN_ADAPTER],
                      pin_change[pmicim_pkg::PMICIM_PIN_BUTTON],
                      evt.thermal_warn,
                      evt.coin_acq_done,
                      evt.prog_done};

  assign rd_flag_sys = rd_hit(req, pmicim_pkg::PMICIM_ADDR_FLAG_SYS);
  assign rd_flag_sw = rd_hit(req, pmicim_pkg::PMICIM_ADDR_FLAG_SW);
  // flags are read-to-clear
  assign src_clear = {{pmicim_pkg::PMICIM_GRP_W{rd_flag_sw}},
                      {pmicim_pkg::PMICIM_GRP_W{rd_flag_sys}}};
  assign all_mask = {mask_sw_reg, mask_sys_reg};

  // flags ignore the masks so monitoring carries on while masked
  genvar gi;
  generate
    for (gi = 0; gi < pmicim_pkg::PMICIM_SRC_N; gi++)
    begin : g_flag
      pmicim_src_flag u_flag (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_in(src_event[gi]),
        .clear_in(src_clear[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  // masks, interrupt, status and control
  always_comb
  begin
    mask_sys_next = mask_sys_reg;
    mask_sw_next = mask_sw_reg;
    if (wr_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SYS))
    begin
      mask_sys_next = req.wdata[pmicim_pkg::PMICIM_GRP_W-1:0];
    end
    if (wr_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SW))
    begin
      mask_sw_next = req.wdata[pmicim_pkg::PMICIM_GRP_W-1:0];
    end
    irq_next = ~|(flags & ~all_mask);
    status_next = {mon.freshness_seal_broken,
                   mon.nvm_defaults_modified,
                   ~mon.adapter_detect_pin,
                   ~mon.push_button_pin,
                   mon.power_state,
                   mon.coin_cell_level};
    pins_prev_next = pins_now;
    primed_next = 1'b1;
    // one-cycle start pulse, reads back as 1 only in that cycle
    acq_next = wr_hit(req, pmicim_pkg::PMICIM_ADDR_CONTROL)
               && req.wdata[pmicim_pkg::PMICIM_CTL_ACQ];
  end

  // read answer, one cycle after the request
  always_comb
  begin
    rvalid_next = req.rd;
    rdata_next = pmicim_pkg::PMICIM_DATA_ZERO;
    if (req.rd)
    begin
      case (req.addr)
        pmicim_pkg::PMICIM_ADDR_FLAG_SYS:
          rdata_next = {pmicim_pkg::PMICIM_RSVD, flags[pmicim_pkg::PMICIM_GRP_W-1:0]};
        pmicim_pkg::PMICIM_ADDR_FLAG_SW:
          rdata_next = {pmicim_pkg::PMICIM_RSVD,
                        flags[pmicim_pkg::PMICIM_SRC_N-1:pmicim_pkg::PMICIM_GRP_W]};
        pmicim_pkg::PMICIM_ADDR_MASK_SYS:
          rdata_next = {pmicim_pkg::PMICIM_RSVD, mask_sys_reg};
        pmicim_pkg::PMICIM_ADDR_MASK_SW:
          rdata_next = {pmicim_pkg::PMICIM_RSVD, mask_sw_reg};
        pmicim_pkg::PMICIM_ADDR_STATUS:
          rdata_next = status_reg;
        pmicim_pkg::PMICIM_ADDR_CONTROL:
          rdata_next = {7'h00, acq_reg};
        default:
          rdata_next = pmicim_pkg::PMICIM_DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mask_sys_reg <= pmicim_pkg::PMICIM_MASK_RST;
      mask_sw_reg <= pmicim_pkg::PMICIM_MASK_RST;
      status_reg <= pmicim_pkg::PMICIM_STATUS_RST;
      pins_prev_reg <= pmicim_pkg::PMICIM_PINS_IDLE;
      primed_reg <= 1'b0;
      acq_reg <= 1'b0;
      irq_reg <= 1'b1;
      rdata_reg <= pmicim_pkg::PMICIM_DATA_ZERO;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      mask_sys_reg <= mask_sys_next;
      mask_sw_reg <= mask_sw_next;
      status_reg <= status_next;
      pins_prev_reg <= pins_prev_next;
      primed_reg <= primed_next;
      acq_reg <= acq_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign coin_acq_start = acq_reg;
  assign irq_out_low = irq_reg;

  // checks
  sequence s_acq_pulse;
    coin_acq_start ##1 !coin_acq_start;
  endsequence

  sequence s_pin_flag(int idx);
    ##1 flags[idx];
  endsequence

  sequence s_sys_wr_rd;
    wr_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SYS) && !req.rd ##1
      rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SYS);
  endsequence

  a_irq_unmasked_low: assert property (@(posedge sys_clk) disable iff (rst)
    (|(flags & ~all_mask)) |=> !irq_out_low)
    else $error("unmasked pending flag did not pull interrupt low");

  a_irq_release_idle: assert property (@(posedge sys_clk) disable iff (rst)
    ((flags & ~all_mask) == '0) |=> irq_out_low)
    else $error("interrupt held low with no unmasked flag");

  a_masked_still_flag: assert property (@(posedge sys_clk) disable iff (rst)
    ((src_event & all_mask) != '0) |=>
      ((flags & $past(src_event & all_mask)) == $past(src_event & all_mask)))
    else $error("masked source event was not flagged");

  a_mask_sys_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SYS) |=>
      reg_rvalid && (reg_rdata == {pmicim_pkg::PMICIM_RSVD, $past(mask_sys_reg)}))
    else $error("system mask readback wrong");

  a_mask_sw_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SW) && !req.rd ##1
      rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SW) |=>
      (reg_rdata[5:0] == $past(req.wdata[5:0], 2)) && (reg_rdata[7:6] == 2'h0))
    else $error("switch mask write not read back");

  a_mask_sw_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (mask_sw_reg == pmicim_pkg::PMICIM_MASK_RST))
    else $error("switch mask not zero after reset");

  a_status_seal_nvm: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_reg[7:6] == $past({mon.freshness_seal_broken, mon.nvm_defaults_modified}))
    else $error("seal or nvm status bit wrong");

  a_status_pin_levels: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_reg[5:4] == ~$past({mon.adapter_detect_pin, mon.push_button_pin}))
    else $error("pin level status bits not inverted pin levels");

  a_status_fields: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_reg[3:0] == $past({mon.power_state, mon.coin_cell_level}))
    else $error("state or coin level field wrong");

  a_status_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (status_reg[7:6] == 2'h0))
    else $error("status upper bits not zero after reset");

  a_acq_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_hit(req, pmicim_pkg::PMICIM_ADDR_CONTROL) && req.wdata[pmicim_pkg::PMICIM_CTL_ACQ]
      |=> s_acq_pulse)
    else $error("acquisition start did not pulse and self clear");

  a_pin_change_flag: assert property (@(posedge sys_clk) disable iff (rst)
    primed_reg && (mon.adapter_detect_pin != pins_prev_reg[pmicim_pkg::PMICIM_PIN_ADAPTER])
      |-> s_pin_flag(pmicim_pkg::PMICIM_SRC_ADAPTER))
    else $error("adapter pin change did not set its flag");

  a_mask_sys_write: assert property (@(posedge sys_clk) disable iff (rst)
    s_sys_wr_rd |=> (reg_rdata[5:0] == $past(req.wdata[5:0], 2)))
    else $error("system mask write not read back");

  a_mask_sw_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SW) |=>
      reg_rvalid && (reg_rdata == {pmicim_pkg::PMICIM_RSVD, $past(mask_sw_reg)}))
    else $error("switch mask readback wrong");

  a_mask_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SYS) ||
      rd_hit(req, pmicim_pkg::PMICIM_ADDR_MASK_SW))
      |=> (reg_rdata[7:6] == pmicim_pkg::PMICIM_RSVD))
    else $error("reserved mask bits not read as zero");

  a_status_readback: assert property (@(posedge sys_clk) disable iff (rst)
    rd_hit(req, pmicim_pkg::PMICIM_ADDR_STATUS) |=>
      reg_rvalid && (reg_rdata == $past(status_reg)))
    else $error("status readback differs from status register");

  a_acq_idle_low: assert property (@(posedge sys_clk) disable iff (rst)
    !(wr_hit(req, pmicim_pkg::PMICIM_ADDR_CONTROL) && req.wdata[pmicim_pkg::PMICIM_CTL_ACQ])
      |=> !coin_acq_start)
    else $error("acquisition start pulsed without a start write");

  a_button_change_flag: assert property (@(posedge sys_clk) disable iff (rst)
    primed_reg && (mon.push_button_pin != pins_prev_reg[pmicim_pkg::PMICIM_PIN_BUTTON])
      |-> s_pin_flag(pmicim_pkg::PMICIM_SRC_BUTTON))
    else $error("button pin change did not set its flag");

  a_irq_reset_high: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> irq_out_low)
    else $error("interrupt not released after reset");

  a_flag_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rd_flag_sys && (src_event[pmicim_pkg::PMICIM_GRP_W-1:0] == '0)
      |=> (flags[pmicim_pkg::PMICIM_GRP_W-1:0] == '0))
    else $error("system flags not cleared by their read");

endmodule
`default_nettype wire

// File: testbench/pmicim_host_model.sv
// host processor model: issues register reads and writes one at a time
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`default_nettype none
module pmicim_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output var pmicim_pkg::pmicim_req_t req
);
  initial req = '0;

  // request raised after a falling edge, held across the taking edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask

  // write then read back in the very next cycle, no idle gap
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(negedge sys_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req.rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask

  // answer stands one cycle, so it is taken in that cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req.rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_pmic_irq_mask_status.sv
// self-checking bench for the interrupt mask and status block
// assumes the host model is the only requester on the register port
`timescale 1ns/1ps
`default_nettype none
module test_pmic_irq_mask_status;
  logic sys_clk;
  logic rst;
  pmicim_pkg::pmicim_evt_t evt;
  pmicim_pkg::pmicim_mon_t mon;
  pmicim_pkg::pmicim_req_t req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic coin_acq_start;
  logic irq_out_low;
  integer seed = 69410;
  integer failures = 0;
  integer total_checks = 0;
  integer mdl_mask [2];
  integer n, i, grp, b, ebit;
  logic [7:0] d, mv;
  logic v;
  logic [7:0] exp_q[$];

  pmic_irq_mask_status u_pmic_irq_mask_status (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(req),
    .evt(evt),
    .mon(mon),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .coin_acq_start(coin_acq_start),
    .irq_out_low(irq_out_low)
  );

  pmicim_host_model u_pmicim_host_model (
    .sys_clk(sys_clk),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .req(req)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // whole run is a few hundred cycles; the margin is generous
  initial
  begin
    #(20000 * 4);
    failures = failures + 1;
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    evt = '0;
    // both pins idle high, everything else zero
    mon = pmicim_pkg::pmicim_mon_t'(8'h30);
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    u_pmicim_host_model.read_reg(8'h03, d, v);
    check(d, 8'h00);
    u_pmicim_host_model.read_reg(8'h04, d, v);
    check(d, 8'h00);
    u_pmicim_host_model.read_reg(8'h05, d, v);
    check(d & 8'hc0, 8'h00);
    check({7'h00, irq_out_low}, 8'h01);
    // every source twice, so each pin changes in both directions
    for (n = 0; n < 24; n = n + 1)
    begin
      i = n % 12;
      grp = i / 6;
      b = i % 6;
      mv = 8'($random(seed));
      mdl_mask[grp] = mv & 8'h3f;
      u_pmicim_host_model.write_read(grp ? 8'h04 : 8'h03, mv, d, v);
      check(d, mdl_mask[grp][7:0]);
      ebit = (i >= 6) ? i - 6 : (i == 0) ? 6 : (i == 1) ? 7 : (i == 2) ? 8 : 9;
      @(negedge sys_clk);
      if (i == 3)
        mon.push_button_pin = ~mon.push_button_pin;
      else if (i == 4)
        mon.adapter_detect_pin = ~mon.adapter_detect_pin;
      else
        evt = pmicim_pkg::pmicim_evt_t'(10'h001 << ebit);
      @(negedge sys_clk);
      evt = '0;
      repeat (2) @(negedge sys_clk);
      check({7'h00, irq_out_low}, {7'h00, mv[b]});
      u_pmicim_host_model.read_reg(grp ? 8'h02 : 8'h01, d, v);
      check(d, 8'h01 << b);
      check({7'h00, v}, 8'h01);
      @(negedge sys_clk);
      check({7'h00, irq_out_low}, 8'h01);
    end
    // reset again with random masks in place, so the zero reset value is seen
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check({7'h00, irq_out_low}, 8'h01);
    u_pmicim_host_model.read_reg(8'h04, d, v);
    check(d, 8'h00);
    u_pmicim_host_model.read_reg(8'h03, d, v);
    check(d, 8'h00);
    u_pmicim_host_model.write_reg(8'h06, 8'h01);
    check({7'h00, coin_acq_start}, 8'h01);
    @(negedge sys_clk);
    check({7'h00, coin_acq_start}, 8'h00);
    for (n = 0; n < 8; n = n + 1)
    begin
      mv = 8'($random(seed));
      mv[3:0] = {n[1:0], 2'(3 - n[1:0])};
      @(negedge sys_clk);
      mon = pmicim_pkg::pmicim_mon_t'(mv);
      exp_q.push_back({mv[7:6], ~mv[5:4], mv[3:0]});
      repeat (2) @(negedge sys_clk);
      u_pmicim_host_model.read_reg(8'h05, d, v);
      check(d, exp_q.pop_front());
    end
    u_pmicim_host_model.read_reg(8'h7f, d, v);
    check(d, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
